/* inc/nvs_cfg.svh */
// offsets, field positions, reset values and timing counts of the nvm block
`ifndef NVS_CFG_SVH
`define NVS_CFG_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define NVS_REG_CLOCK_GATE   8'h42
`define NVS_REG_ENABLE_CFG   8'h51
`define NVS_REG_TARGET_ADDR  8'h52
`define NVS_REG_DATA_BYTE    8'h53
`define NVS_REG_COMMAND      8'h54
`define NVS_REG_RESULT_STAT  8'h58
`define NVS_MEM_FIRST        8'hDF
`define NVS_MEM_LAST         8'hE8
`define NVS_MEM_DEPTH        10
`define NVS_USE_CFG_INDEX    4'h0
`define NVS_LOCK_WORD_INDEX  4'h9

// ****************************************************************
// field positions
// ****************************************************************
`define NVS_CLK_EN_BIT       0
`define NVS_MEM_EN_BIT       0
`define NVS_CMD_WR_BIT       0
`define NVS_CMD_RD_BIT       1
`define NVS_CMD_LOCK_BIT     2
`define NVS_ST_WR_OK_BIT     0
`define NVS_ST_LOCK_OK_BIT   1
`define NVS_ST_CRC_OK_BIT    2

// ****************************************************************
// reset values and timing
// ****************************************************************
`define NVS_RESET_BYTE       8'h00
`define NVS_CRC_INIT         8'hFF
`define NVS_CRC_POLY         8'h07
`define NVS_PROG_TIME_NS     1000
`define NVS_CLK_PERIOD_NS    10
`define NVS_PROG_CYCLES      \
   ((`NVS_PROG_TIME_NS + `NVS_CLK_PERIOD_NS - 1) / `NVS_CLK_PERIOD_NS)
`define NVS_READ_CYCLES      4

`endif

/* inc/nvs_pkg.sv */
// types shared by the nvm sequencer files
package nvs_pkg;
   typedef enum logic [4:0] {
      NVS_IDLE  = 5'h01,
      NVS_PROG  = 5'h02,
      NVS_READ  = 5'h04,
      NVS_CHECK = 5'h08,
      NVS_DONE  = 5'h10
   } nvs_state_t;
   typedef logic [7:0] nvs_byte_t;
endpackage

/* rtl/nvs_crc8.sv */
// one-byte crc step used to check the programmed memory during lock
`timescale 1ns/1ps
`include "nvs_cfg.svh"

module nvs_crc8 (
   input  wire logic [7:0] crc_i,   // running check value
   input  wire logic [7:0] data_i,  // next byte
   output logic      [7:0] crc_o    // updated check value
);
   // ****************************************************************
   // bitwise update
   // ****************************************************************
   // shift one bit at a time through the polynomial
   always_comb begin
      logic [7:0] c;
      c = crc_i ^ data_i;
      for (int i = 0; i < 8; i++) begin
         c = c[7] ? ({c[6:0], 1'b0} ^ `NVS_CRC_POLY) : {c[6:0], 1'b0};
      end
      crc_o = c;
   end
endmodule // nvs_crc8

/* rtl/nvs_sequencer.sv */
// nvm program, read and lock sequencer behind vendor register requests
// How it works
// [RQ1] memory bytes sit at register addresses 0xDF through 0xE8.
// [RQ2] all access uses vendor register write and read requests.
// [RQ3] with use setting nonzero, unprogrammed bytes count as zero.
// [RQ4] host may skip writing bytes whose value is zero.
// [RQ5] memory logic runs only while the clock gate bit is set.
// [RQ6] host sets memory enable before each operation.
// [RQ7] host loads the target address before a command.
// [RQ8] host loads the data byte before a write.
// [RQ9] write bit starts programming, self clears when done.
// [RQ10] write ok bit reports success; host retries on zero.
// [RQ11] host gives up after ten failed write retries.
// [RQ12] read bit starts a read, self clears when done.
// [RQ13] read byte appears in the data register after completion.
// [RQ14] host locks after writing the lock word location.
// [RQ15] host must not reset between lock word write and lock.
// [RQ16] lock bit starts locking, self clears when done.
// [RQ17] lock ok and crc ok report lock result.
// [RQ18] host gives up after ten failed lock retries.
// [RQ19] write request: address and value bytes, value stored.
// [RQ20] read request: address byte, current value returned.
// [RQ21] new command bits ignored while one is still busy.
// [RQ22] lock computes a check over contents for crc ok.
`timescale 1ns/1ps
`include "nvs_cfg.svh"

module nvs_sequencer (
   input  wire logic       ref_clk_i,    // 100 MHz clock
   input  wire logic       sys_rst_i,    // sync reset, usb or power-on
   input  wire logic       reg_wr_i,     // vendor write request strobe
   input  wire logic       reg_rd_i,     // vendor read request strobe
   input  wire logic [7:0] reg_addr_i,   // index low byte
   input  wire logic [7:0] reg_wdata_i,  // index high byte
   output logic      [7:0] reg_rdata_o,  // read answer
   output logic            reg_rvalid_o, // read answer valid pulse
   output logic            use_cfg_o,    // memory configuration in use
   output logic            locked_o      // memory locked
);
   // ****************************************************************
   // storage
   // ****************************************************************
   nvs_pkg::nvs_byte_t  clock_gate, enable_cfg, target_addr, data_byte;
   logic [2:0]          command;
   logic [2:0]          result;
   nvs_pkg::nvs_byte_t  mem [`NVS_MEM_DEPTH];
   logic [`NVS_MEM_DEPTH-1:0] written;
   nvs_pkg::nvs_state_t state;
   logic [7:0]          timer;
   logic [3:0]          scan;
   logic [7:0]          crc, ref_crc, next_crc;
   logic                locked;

   // decode a register address into a memory slot
   function automatic logic in_mem(input logic [7:0] a);
      return (a >= `NVS_MEM_FIRST) && (a <= `NVS_MEM_LAST);
   endfunction
   function automatic logic [3:0] slot(input logic [7:0] a);
      logic [7:0] d;
      d = a - `NVS_MEM_FIRST;
      return d[3:0];
   endfunction

   wire logic clk_on  = clock_gate[`NVS_CLK_EN_BIT];          // RQ5
   wire logic mem_en  = enable_cfg[`NVS_MEM_EN_BIT];
   wire logic busy    = |command;                             // RQ21
   wire logic ok_addr = in_mem(target_addr);
   wire logic [3:0] tslot = slot(target_addr);

   nvs_crc8 u_crc (
      .crc_i  (crc),
      .data_i (mem[scan]),
      .crc_o  (next_crc)
   );

   // ****************************************************************
   // host registers
   // ****************************************************************
   // plain rw registers, written by vendor write requests
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         clock_gate  <= `NVS_RESET_BYTE;
         enable_cfg  <= `NVS_RESET_BYTE;
         target_addr <= `NVS_RESET_BYTE;
      end else if (reg_wr_i) begin                            // RQ19 RQ2
         case (reg_addr_i)
            `NVS_REG_CLOCK_GATE:  clock_gate  <= reg_wdata_i;
            `NVS_REG_ENABLE_CFG:  enable_cfg  <= reg_wdata_i;
            `NVS_REG_TARGET_ADDR: target_addr <= reg_wdata_i;
            default: ;
         endcase
      end
   end

   // data register: host writes, read completion loads memory byte
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         data_byte <= `NVS_RESET_BYTE;
      end else if (state == nvs_pkg::NVS_READ && timer == 8'h00) begin
         data_byte <= (ok_addr && written[tslot]) ? mem[tslot]
                                                  : 8'h00;    // RQ13 RQ3
      end else if (reg_wr_i && reg_addr_i == `NVS_REG_DATA_BYTE) begin
         data_byte <= reg_wdata_i;
      end
   end

   // ****************************************************************
   // command sequencer
   // ****************************************************************
   // command bits: set by host when idle, cleared by hardware on finish
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         command <= 3'h0;
      end else if (state == nvs_pkg::NVS_DONE) begin
         command <= 3'h0;                                     // RQ9 RQ12 RQ16
      end else if (reg_wr_i && reg_addr_i == `NVS_REG_COMMAND
                   && !busy && clk_on && mem_en) begin        // RQ21 RQ5
         if (reg_wdata_i[`NVS_CMD_WR_BIT])
            command <= 3'h1;
         else if (reg_wdata_i[`NVS_CMD_RD_BIT])
            command <= 3'h2;
         else if (reg_wdata_i[`NVS_CMD_LOCK_BIT])
            command <= 3'h4;
      end
   end

   // state machine running the started operation
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         state <= nvs_pkg::NVS_IDLE;
         timer <= 8'h00;
         scan  <= 4'h0;
      end else if (clk_on) begin                              // RQ5
         case (state)
            nvs_pkg::NVS_IDLE: begin
               scan <= 4'h0;
               if (command[`NVS_CMD_WR_BIT]) begin            // RQ9
                  state <= nvs_pkg::NVS_PROG;
                  timer <= 8'(`NVS_PROG_CYCLES - 1);
               end else if (command[`NVS_CMD_RD_BIT]) begin   // RQ12
                  state <= nvs_pkg::NVS_READ;
                  timer <= 8'(`NVS_READ_CYCLES - 1);
               end else if (command[`NVS_CMD_LOCK_BIT]) begin // RQ16
                  state <= nvs_pkg::NVS_CHECK;
               end
            end
            nvs_pkg::NVS_PROG, nvs_pkg::NVS_READ: begin
               if (timer == 8'h00)
                  state <= nvs_pkg::NVS_DONE;
               else
                  timer <= timer - 8'h01;
            end
            nvs_pkg::NVS_CHECK: begin                         // RQ22
               if (scan == 4'(`NVS_MEM_DEPTH - 1))
                  state <= nvs_pkg::NVS_DONE;
               else
                  scan <= scan + 4'h1;
            end
            nvs_pkg::NVS_DONE: state <= nvs_pkg::NVS_IDLE;
            default:           state <= nvs_pkg::NVS_IDLE;
         endcase
      end
   end

   // ****************************************************************
   // memory, check value and results
   // ****************************************************************
   // program a byte at the end of the write; locked memory refuses it
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         written <= '0;
         for (int i = 0; i < `NVS_MEM_DEPTH; i++)
            mem[i] <= 8'h00;
      end else if (state == nvs_pkg::NVS_PROG && timer == 8'h00
                   && ok_addr && !locked) begin
         mem[tslot]     <= data_byte;
         written[tslot] <= 1'b1;
      end
   end

   // running check over all slots; reference caught at lock time
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         crc     <= `NVS_CRC_INIT;
         ref_crc <= `NVS_CRC_INIT;
      end else if (state == nvs_pkg::NVS_IDLE) begin
         crc <= `NVS_CRC_INIT;
      end else if (state == nvs_pkg::NVS_CHECK) begin
         crc <= next_crc;                                     // RQ22
         if (scan == 4'h0 && !locked)
            ref_crc <= 8'h00;
      end else if (state == nvs_pkg::NVS_DONE && command[2] && !locked) begin
         ref_crc <= crc;
      end
   end

   // result bits and lock flag
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         result <= 3'h0;
         locked <= 1'b0;
      end else if (state == nvs_pkg::NVS_DONE) begin
         if (command[`NVS_CMD_WR_BIT])
            result[`NVS_ST_WR_OK_BIT] <= ok_addr && !locked && 
                                         mem[tslot] == data_byte; // RQ10
         if (command[`NVS_CMD_LOCK_BIT]) begin                // RQ17
            result[`NVS_ST_LOCK_OK_BIT] <= written[`NVS_LOCK_WORD_INDEX];
            result[`NVS_ST_CRC_OK_BIT]  <= locked ? (crc == ref_crc)
                                                  : 1'b1;     // RQ22
            locked <= locked | written[`NVS_LOCK_WORD_INDEX];
         end
      end
   end

   // ****************************************************************
   // read answers and outputs
   // ****************************************************************
   // vendor read request returns the addressed register one cycle later
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         reg_rdata_o  <= 8'h00;
         reg_rvalid_o <= 1'b0;
         use_cfg_o    <= 1'b0;
         locked_o     <= 1'b0;
      end else begin
         reg_rvalid_o <= reg_rd_i;                            // RQ20
         use_cfg_o    <= written[`NVS_USE_CFG_INDEX]
                         && mem[`NVS_USE_CFG_INDEX] != 8'h00; // RQ3
         locked_o     <= locked;
         if (reg_rd_i) begin
            case (reg_addr_i)
               `NVS_REG_CLOCK_GATE:  reg_rdata_o <= clock_gate;
               `NVS_REG_ENABLE_CFG:  reg_rdata_o <= enable_cfg;
               `NVS_REG_TARGET_ADDR: reg_rdata_o <= target_addr;
               `NVS_REG_DATA_BYTE:   reg_rdata_o <= data_byte;
               `NVS_REG_COMMAND:     reg_rdata_o <= {5'h00, command};
               `NVS_REG_RESULT_STAT: reg_rdata_o <= {5'h00, result};
               default: reg_rdata_o <= in_mem(reg_addr_i)
                                       ? mem[slot(reg_addr_i)]
                                       : 8'h00;               // RQ1
            endcase
         end
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   AST_CMD_CLEARS: assert property ( // RQ9
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      state == nvs_pkg::NVS_DONE |=> command == 3'h0)
      else $error("command bit not cleared at completion");
   AST_ONE_AT_A_TIME: assert property ( // RQ21
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      $countones(command) <= 1)
      else $error("more than one command bit set");
   AST_HOLD_BUSY: assert property ( // RQ21
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      busy && state != nvs_pkg::NVS_DONE |=> $stable(command))
      else $error("busy command changed early");
   AST_STATE_ONEHOT: assert property ( // RQ21
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      $onehot(state))
      else $error("sequencer state not one-hot");
   AST_NO_CLK_NO_START: assert property ( // RQ5
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      !clk_on |=> $stable(state))
      else $error("sequencer moved without clock gate");
   AST_PROG_DONE: assert property ( // RQ9
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      state == nvs_pkg::NVS_IDLE && command == 3'h1 && clk_on
      |=> ##[99:100] state == nvs_pkg::NVS_DONE)
      else $error("write did not finish in time");
   AST_LOCKED_NO_WRITE: assert property ( // RQ10
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      state == nvs_pkg::NVS_DONE && command == 3'h1 && locked
      |=> !result[`NVS_ST_WR_OK_BIT])
      else $error("write reported ok on locked memory");
   AST_READ_DONE: assert property ( // RQ12
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      state == nvs_pkg::NVS_IDLE && command == 3'h2 && clk_on
      |=> ##[3:4] state == nvs_pkg::NVS_DONE)
      else $error("read did not finish in time");
   AST_READ_DATA: assert property ( // RQ13
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      state == nvs_pkg::NVS_DONE && command == 3'h2 && ok_addr
      && written[tslot] |-> data_byte == mem[tslot])
      else $error("read data not presented");
   AST_LOCK_OK: assert property ( // RQ17
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      state == nvs_pkg::NVS_DONE && command == 3'h4
      |=> result[`NVS_ST_LOCK_OK_BIT] == $past(written[`NVS_LOCK_WORD_INDEX]))
      else $error("lock ok does not follow the lock word");
   AST_READ_ANSWER: assert property ( // RQ20
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      reg_rd_i |=> reg_rvalid_o)
      else $error("read request not answered");
   AST_STATUS_READ: assert property ( // RQ17
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      reg_rd_i && reg_addr_i == `NVS_REG_RESULT_STAT
      |=> reg_rdata_o == {5'h00, $past(result)})
      else $error("status read wrong");
   AST_WRITE_STORE: assert property ( // RQ19
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      reg_wr_i && reg_addr_i == `NVS_REG_TARGET_ADDR
      |=> target_addr == $past(reg_wdata_i))
      else $error("register write not stored");
   AST_MEM_WINDOW: assert property ( // RQ1
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      reg_rd_i && reg_addr_i == `NVS_MEM_FIRST
      |=> reg_rdata_o == $past(mem[0]))
      else $error("memory window read wrong");
   COV_WRITE: cover property (@(posedge ref_clk_i)
      state == nvs_pkg::NVS_PROG ##[1:200] state == nvs_pkg::NVS_DONE);
   COV_READ: cover property (@(posedge ref_clk_i)
      state == nvs_pkg::NVS_READ ##[1:8] state == nvs_pkg::NVS_DONE);
   COV_LOCK: cover property (@(posedge ref_clk_i) locked && result[2]);
   COV_BUSY_DROP: cover property (@(posedge ref_clk_i)
      reg_wr_i && reg_addr_i == `NVS_REG_COMMAND && busy);
endmodule // nvs_sequencer

/* sim/nvs_host.sv */
// host model that issues vendor register requests to the nvm sequencer
`timescale 1ns/1ps
module nvs_host (
   input  wire logic       ref_clk_i,   // bench clock
   output logic            reg_wr_o,    // write strobe
   output logic            reg_rd_o,    // read strobe
   output logic      [7:0] reg_addr_o,  // index low byte
   output logic      [7:0] reg_wdata_o, // index high byte
   input  wire logic [7:0] reg_rdata_i, // read answer
   input  wire logic       reg_rvalid_i // answer valid
);
   logic hung; // a bounded wait ran out
   // idle bus at time zero
   initial begin
      {reg_wr_o, reg_rd_o, hung} = 3'h0;
      {reg_addr_o, reg_wdata_o} = 16'h0000;
   end
   // one write request; released lines toggle so stale values never pass
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge ref_clk_i);
      {reg_addr_o, reg_wdata_o, reg_wr_o} = {a, v, 1'b1};
      @(negedge ref_clk_i);
      {reg_addr_o, reg_wdata_o, reg_wr_o} = {~a, ~v, 1'b0};
   endtask
   // one read request, answer taken in its valid cycle
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      int n;
      v = 8'hXX;
      @(negedge ref_clk_i);
      {reg_addr_o, reg_rd_o} = {a, 1'b1};
      @(negedge ref_clk_i);
      {reg_addr_o, reg_rd_o} = {~a, 1'b0};
      for (n = 0; n < 3 && reg_rvalid_i !== 1'b1; n++)
         @(negedge ref_clk_i);
      if (reg_rvalid_i === 1'b1)
         v = reg_rdata_i;
      else
         hung = 1'b1;
   endtask
   // wait for the command byte to self clear
   task automatic poll();
      logic [7:0] c;
      int n;
      c = 8'hFF;
      for (n = 0; n < 300 && c !== 8'h00; n++)
         rd(8'h54, c);
      if (c !== 8'h00)
         hung = 1'b1;
   endtask
   // clock gate then memory enable, done before every operation
   task automatic enable();
      wr(8'h42, 8'h01);
      wr(8'h51, 8'h01);
   endtask
   // program one byte, retrying from the data step; zero is skipped
   task automatic write_byte(input logic [7:0] a, input logic [7:0] v,
                             output logic ok);
      logic [7:0] s;
      int t;
      ok = (v === 8'h00);
      enable();
      wr(8'h52, a);
      for (t = 0; t < 10 && ok !== 1'b1; t++) begin
         wr(8'h53, v);
         wr(8'h54, 8'h01);
         poll();
         rd(8'h58, s);
         ok = s[0];
      end
   endtask
   // read one byte back through the data register
   task automatic read_byte(input logic [7:0] a, output logic [7:0] v);
      enable();
      wr(8'h52, a);
      wr(8'h54, 8'h02);
      poll();
      rd(8'h53, v);
   endtask
   // lock, repeating from the enable step until both bits are set
   task automatic lock_seq(output logic [7:0] s);
      int t;
      s = 8'h00;
      for (t = 0; t < 10 && s[2:1] !== 2'b11; t++) begin
         enable();
         wr(8'h54, 8'h04);
         poll();
         rd(8'h58, s);
      end
   endtask
endmodule // nvs_host

/* sim/nvs_sequencer_tb.sv */
// self-checking bench for the nvm program, read and lock sequencer
`timescale 1ns/1ps
module nvs_sequencer_tb;
   logic       ref_clk_i;    // bench clock
   logic       sys_rst_i;    // sync reset
   logic       reg_wr_i;     // write strobe
   logic       reg_rd_i;     // read strobe
   logic [7:0] reg_addr_i;   // register address
   logic [7:0] reg_wdata_i;  // write value
   logic [7:0] reg_rdata_o;  // read answer
   logic       reg_rvalid_o; // answer valid
   logic       use_cfg_o;    // configuration in use
   logic       locked_o;     // memory locked
   int         mismatches;
   int         total_checks;
   int         seed;
   int         i;
   logic [7:0] mem [10];     // model of the memory slots
   logic [7:0] g;
   logic [7:0] s;
   logic       ok;
   logic [7:0] ra [7] = '{8'h42, 8'h51, 8'h52, 8'h53, 8'h54, 8'h58, 8'h60};

   // ****************************************************************
   // clock, design and host
   // ****************************************************************
   always #5 ref_clk_i = ~ref_clk_i;
   nvs_sequencer nvs_sequencer_inst (.ref_clk_i(ref_clk_i),
      .sys_rst_i(sys_rst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
      .use_cfg_o(use_cfg_o), .locked_o(locked_o));
   nvs_host nvs_host_inst (.ref_clk_i(ref_clk_i), .reg_wr_o(reg_wr_i),
      .reg_rd_o(reg_rd_i), .reg_addr_o(reg_addr_i),
      .reg_wdata_o(reg_wdata_i), .reg_rdata_i(reg_rdata_o),
      .reg_rvalid_i(reg_rvalid_o));

   // compare tasks, closing report and end of each test
   function automatic logic [7:0] rnd8();
      return 8'($random(seed));
   endfunction
   task automatic check8(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t byte %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check1(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic done(input string t);
      check1(nvs_host_inst.hung, 1'b0);
      $display("test %s done", t);
      if (nvs_host_inst.hung)
         report_and_stop();
   endtask
   // watchdog behind the bounded waits
   initial begin
      #300000;
      mismatches++;
      report_and_stop();
   end

   // main sequence
   initial begin
      {ref_clk_i, sys_rst_i} = 2'b01;
      {mismatches, total_checks, seed} = {32'd0, 32'd0, 32'd74};
      for (i = 0; i < 10; i++)
         mem[i] = 8'h00;
      repeat (6) @(negedge ref_clk_i);
      sys_rst_i = 1'b0;
      // every register and an unmapped place read zero after reset
      for (i = 0; i < 7; i++) begin
         nvs_host_inst.rd(ra[i], g);
         check8(g, 8'h00);
      end
      check1(locked_o, 1'b0);
      done("reset");
      // plain registers hold values; status and gated commands refuse
      for (i = 0; i < 4; i++) begin
         s = rnd8();
         nvs_host_inst.wr(ra[i], s);
         nvs_host_inst.rd(ra[i], g);
         check8(g, s);
      end
      nvs_host_inst.wr(8'h58, 8'hFF);
      nvs_host_inst.rd(8'h58, g);
      check8(g, 8'h00);
      nvs_host_inst.wr(8'h42, 8'h00);
      nvs_host_inst.wr(8'h51, 8'h01);
      nvs_host_inst.wr(8'h54, 8'h01);
      nvs_host_inst.rd(8'h54, g);
      check8(g, 8'h00);
      done("registers");
      // unprogrammed slot reads zero, then slots written and read back
      nvs_host_inst.read_byte(8'hDF, g);
      check8(g, 8'h00);
      check1(use_cfg_o, 1'b0);
      for (i = 1; i < 8; i++) begin
         mem[i] = rnd8();
         nvs_host_inst.write_byte(8'hDF + 8'(i), mem[i], ok);
         check1(ok, 1'b1);
      end
      for (i = 1; i < 8; i++) begin
         nvs_host_inst.read_byte(8'hDF + 8'(i), g);
         check8(g, mem[i]);
      end
      mem[0] = rnd8() | 8'h01;
      nvs_host_inst.write_byte(8'hDF, mem[0], ok);
      check1(ok, 1'b1);
      check1(use_cfg_o, 1'b1);
      // the window reads back directly and refuses plain writes
      nvs_host_inst.wr(8'hDF, ~mem[0]);
      nvs_host_inst.rd(8'hDF, g);
      check8(g, mem[0]);
      done("write read");
      // a lock command while programming is busy is dropped
      mem[8] = (rnd8() & 8'h7E) | 8'h01; // inverse never zero
      nvs_host_inst.enable();
      nvs_host_inst.wr(8'h52, 8'hE7);
      nvs_host_inst.wr(8'h53, mem[8]);
      nvs_host_inst.wr(8'h54, 8'h01);
      nvs_host_inst.wr(8'h54, 8'h04);
      nvs_host_inst.poll();
      nvs_host_inst.rd(8'h58, s);
      check8(s, 8'h01);
      check1(locked_o, 1'b0);
      done("busy");
      // lock before the lock word is written fails on every retry
      nvs_host_inst.lock_seq(s);
      check8(s & 8'h06, 8'h04);
      check1(locked_o, 1'b0);
      done("early lock");
      // lock word written, lock run twice with no reset in between
      mem[9] = rnd8() | 8'h01;
      nvs_host_inst.write_byte(8'hE8, mem[9], ok);
      check1(ok, 1'b1);
      nvs_host_inst.lock_seq(s);
      check8(s & 8'h06, 8'h06);
      check1(locked_o, 1'b1);
      nvs_host_inst.lock_seq(s);
      check8(s & 8'h06, 8'h06);
      nvs_host_inst.write_byte(8'hE7, ~mem[8], ok);
      check1(ok, 1'b0);
      for (i = 8; i < 10; i++) begin
         nvs_host_inst.read_byte(8'hDF + 8'(i), g);
         check8(g, mem[i]);
      end
      done("lock");
      report_and_stop();
   end
endmodule // nvs_sequencer_tb
